// ---- hw/xfer_status_pkg.sv ----
// package for the transfer and field fault status block
package xfer_status_pkg;
    localparam int OVERFLOW_BIT  = 7;
    localparam int CRC_BIT       = 5;
    localparam int LATE_BIT      = 4;
    localparam int ABSENT_BIT    = 2;
    localparam int WBLOCK_BIT    = 1;
    localparam int ADDR_BIT      = 0;
    localparam int CLASH_BIT     = 6;
    localparam int PCRC_BIT      = 5;
    localparam int MISMATCH_BIT  = 4;
    localparam int BADTRK_BIT    = 1;
    localparam int DSYNC_BIT     = 0;
    localparam logic [7:0] LAST_SECTOR   = 8'hff;
    localparam logic [7:0] BAD_CYLINDER  = 8'hff;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] USED1_MASK    = 8'hb7;
    localparam logic [7:0] USED2_MASK    = 8'h73;
    localparam logic [1:0] IC_NORMAL     = 2'h0;
    localparam logic [1:0] IC_ABNORMAL   = 2'h1;
    localparam int INDEX_LIMIT = 2;

    typedef enum logic [2:0] {
        CMD_READ_DATA, CMD_READ_DELETED, CMD_READ_ID, CMD_READ_TRACK,
        CMD_WRITE_DATA, CMD_WRITE_DELETED, CMD_FORMAT, CMD_OTHER
    } cmd_kind_t;

    // events from the read/write datapath, one-cycle pulses
    typedef struct packed {
        logic       sector_step;
        logic [7:0] sector_num;
        logic       id_crc_bad;
        logic       data_crc_bad;
        logic       late_service;
        logic       sector_miss;
        logic       sequence_bad;
        logic       id_seen;
        logic [7:0] id_cylinder;
        logic       data_mark;
        logic       deleted_mark;
        logic       mark_timeout;
        logic       xfer_done;
    } disk_evt_t;

    typedef struct packed {
        logic [7:0] transfer_fault_status;
        logic [7:0] field_fault_status;
        logic [1:0] interrupt_code_field;
    } result_t;
endpackage : xfer_status_pkg

// ---- hw/disk_transfer_error_status.sv ----
// sticky error flags of status bytes one and two
module disk_transfer_error_status (
    input  wire logic                        REF_CLK_I,
    input  wire logic                        RST_I,
    input  wire logic                        CMD_START_I,
    input  wire xfer_status_pkg::cmd_kind_t  CMD_KIND_I,
    input  wire logic                        CMD_ACTIVE_I,
    input  wire logic [7:0]                  PRESENT_TRACK_I,
    input  wire xfer_status_pkg::disk_evt_t  EVT_I,
    input  wire logic                        TRANSFER_COUNT_END_I,
    input  wire logic                        INDEX_PULSE_INPUT_I,
    input  wire logic                        WRITE_PROTECT_I,
    input  wire logic                        RESULT_SEL_I,
    input  wire logic                        RESULT_DONE_I,
    output logic [7:0]                       RESULT_BYTE_O,
    output logic                             RESULT_VALID_O,
    output logic [1:0]                       INTERRUPT_CODE_FIELD_O,
    output logic                             ERROR_O
);
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] next_st1;
    logic [7:0] next_st2;
    logic [1:0] index_cnt;
    logic       wp_q;
    logic       tc_seen;
    logic       held;
    logic       is_write;
    logic       is_read_rw;
    logic       wp_rise;
    logic       cyl_diff;
    logic       any_err;

    ////////////////////////////////////////////////////////////////////////
    assign is_write   = CMD_KIND_I == xfer_status_pkg::CMD_WRITE_DATA ||
                        CMD_KIND_I == xfer_status_pkg::CMD_WRITE_DELETED ||
                        CMD_KIND_I == xfer_status_pkg::CMD_FORMAT;
    assign is_read_rw = CMD_KIND_I == xfer_status_pkg::CMD_READ_DATA ||
                        CMD_KIND_I == xfer_status_pkg::CMD_READ_DELETED ||
                        CMD_KIND_I == xfer_status_pkg::CMD_WRITE_DATA ||
                        CMD_KIND_I == xfer_status_pkg::CMD_WRITE_DELETED;
    assign wp_rise  = WRITE_PROTECT_I && !wp_q;
    assign cyl_diff = EVT_I.id_seen && EVT_I.id_cylinder != PRESENT_TRACK_I;

    always_comb begin
        set1 = 8'h00;
        set2 = 8'h00;
        set1[xfer_status_pkg::OVERFLOW_BIT] =
            (EVT_I.sector_step &&
             EVT_I.sector_num == xfer_status_pkg::LAST_SECTOR) ||
            (EVT_I.xfer_done && is_read_rw && !tc_seen &&
             !TRANSFER_COUNT_END_I);
        set1[xfer_status_pkg::CRC_BIT] = EVT_I.id_crc_bad ||
                                         EVT_I.data_crc_bad;
        set1[xfer_status_pkg::LATE_BIT] = EVT_I.late_service;
        set1[xfer_status_pkg::ABSENT_BIT] =
            (EVT_I.sector_miss &&
             (CMD_KIND_I == xfer_status_pkg::CMD_READ_DATA ||
              CMD_KIND_I == xfer_status_pkg::CMD_READ_DELETED)) ||
            (EVT_I.id_crc_bad &&
             CMD_KIND_I == xfer_status_pkg::CMD_READ_ID) ||
            (EVT_I.sequence_bad &&
             CMD_KIND_I == xfer_status_pkg::CMD_READ_TRACK);
        set1[xfer_status_pkg::WBLOCK_BIT] = wp_rise && is_write;
        set1[xfer_status_pkg::ADDR_BIT] =
            (INDEX_PULSE_INPUT_I && !EVT_I.id_seen &&
             index_cnt == 2'(xfer_status_pkg::INDEX_LIMIT - 1)) ||
            EVT_I.mark_timeout;
        set2[xfer_status_pkg::CLASH_BIT] =
            (EVT_I.deleted_mark &&
             CMD_KIND_I == xfer_status_pkg::CMD_READ_DATA) ||
            (EVT_I.data_mark &&
             CMD_KIND_I == xfer_status_pkg::CMD_READ_DELETED);
        set2[xfer_status_pkg::PCRC_BIT] = EVT_I.data_crc_bad;
        set2[xfer_status_pkg::MISMATCH_BIT] = cyl_diff;
        set2[xfer_status_pkg::BADTRK_BIT] =
            cyl_diff && EVT_I.id_cylinder == xfer_status_pkg::BAD_CYLINDER;
        set2[xfer_status_pkg::DSYNC_BIT] = EVT_I.mark_timeout;
    end

    assign next_st1 = CMD_START_I ? xfer_status_pkg::STATUS_RESET :
                      held ? st1 : (st1 | set1);
    assign next_st2 = CMD_START_I ? xfer_status_pkg::STATUS_RESET :
                      held ? st2 : (st2 | set2);

    ////////////////////////////////////////////////////////////////////////
    // flags freeze once execution ends so late datapath noise
    // cannot change bytes the host is still reading
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st1 <= xfer_status_pkg::STATUS_RESET;
            st2 <= xfer_status_pkg::STATUS_RESET;
            held <= 1'b0;
            // a switch already high at reset is not a new rise
            wp_q <= 1'b1;
            tc_seen <= 1'b0;
            index_cnt <= 2'h0;
        end else begin
            st1 <= next_st1 & xfer_status_pkg::USED1_MASK;
            st2 <= next_st2 & xfer_status_pkg::USED2_MASK;
            wp_q <= WRITE_PROTECT_I;
            if (CMD_START_I) begin
                held <= 1'b0;
                tc_seen <= 1'b0;
                index_cnt <= 2'h0;
            end else begin
                if (!CMD_ACTIVE_I && !held)
                    held <= 1'b1;
                else if (RESULT_DONE_I)
                    held <= 1'b0;
                if (TRANSFER_COUNT_END_I)
                    tc_seen <= 1'b1;
                if (EVT_I.id_seen)
                    index_cnt <= 2'h0;
                else if (INDEX_PULSE_INPUT_I && index_cnt != 2'h3)
                    index_cnt <= index_cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign any_err = (st1 | st2) != 8'h00;
    assign ERROR_O = any_err;
    assign INTERRUPT_CODE_FIELD_O = any_err ? xfer_status_pkg::IC_ABNORMAL
                                            : xfer_status_pkg::IC_NORMAL;
    assign RESULT_VALID_O = held;
    assign RESULT_BYTE_O  = !held ? 8'h00 : RESULT_SEL_I ? st2 : st1;

    ////////////////////////////////////////////////////////////////////////
    property p_crc_sets;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (EVT_I.id_crc_bad && !CMD_START_I && !held) |=>
            st1[xfer_status_pkg::CRC_BIT];
    endproperty
    a_crc_sets: assert property (p_crc_sets)
        else $error("crc flag missed");
    property p_unused_zero;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (st1 & ~xfer_status_pkg::USED1_MASK) == 8'h00 &&
        (st2 & ~xfer_status_pkg::USED2_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bit set");
    property p_start_clears;
        @(posedge REF_CLK_I) disable iff (RST_I)
        CMD_START_I |=> st1 == 8'h00 && st2 == 8'h00;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("no clear");
    property p_badtrk_implies;
        @(posedge REF_CLK_I) disable iff (RST_I)
        st2[xfer_status_pkg::BADTRK_BIT] |->
            st2[xfer_status_pkg::MISMATCH_BIT];
    endproperty
    a_badtrk_implies: assert property (p_badtrk_implies)
        else $error("bad trk");
    property p_pcrc_both;
        @(posedge REF_CLK_I) disable iff (RST_I)
        st2[xfer_status_pkg::PCRC_BIT] |-> st1[xfer_status_pkg::CRC_BIT];
    endproperty
    a_pcrc_both: assert property (p_pcrc_both)
        else $error("payload crc");
    property p_code;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (st1 != 8'h00) |-> INTERRUPT_CODE_FIELD_O == 2'h1;
    endproperty
    a_code: assert property (p_code)
        else $error("interrupt code");
    property p_hold;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (held && !CMD_START_I && !RESULT_DONE_I) |=>
            $stable(st1) && $stable(st2);
    endproperty
    a_hold: assert property (p_hold)
        else $error("flags moved");
    property p_wblock;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (wp_rise && is_write && !CMD_START_I && !held) |=>
            st1[xfer_status_pkg::WBLOCK_BIT];
    endproperty
    a_wblock: assert property (p_wblock)
        else $error("write block");
endmodule : disk_transfer_error_status

// ---- verif/drive_model.sv ----
// drive side model: index pulses and write protect switch
module drive_model (
    input  wire logic clk_i,
    input  wire logic spin_i,
    input  wire logic protect_i,
    output logic      index_o,
    output logic      wp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase = 3'h0;
    initial index_o = 1'b0;
    // one index per turn, none while the disk stands still
    always @(posedge clk_i) begin
        phase   <= spin_i ? phase + 3'h1 : 3'h0;
        index_o <= spin_i && (phase == 3'h7);
    end
    assign wp_o = protect_i;
endmodule : drive_model

// ---- verif/test_disk_transfer_error_status.sv ----
// testbench of the transfer and field fault status block
module test_disk_transfer_error_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, active = 1'b0, tc = 1'b0;
    logic sel = 1'b0, done = 1'b0, spin = 1'b0, prot = 1'b0;
    logic index, wp, valid, err;
    logic [7:0] byte_o;
    logic [1:0] code;
    xfer_status_pkg::cmd_kind_t kind = xfer_status_pkg::CMD_READ_DATA;
    xfer_status_pkg::disk_evt_t evt = '0;
    xfer_status_pkg::disk_evt_t e;
    int miscompares = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    disk_transfer_error_status disk_transfer_error_status_inst (
        .REF_CLK_I(clk), .RST_I(rst), .CMD_START_I(start),
        .CMD_KIND_I(kind), .CMD_ACTIVE_I(active), .PRESENT_TRACK_I(8'h03),
        .EVT_I(evt), .TRANSFER_COUNT_END_I(tc), .INDEX_PULSE_INPUT_I(index),
        .WRITE_PROTECT_I(wp), .RESULT_SEL_I(sel), .RESULT_DONE_I(done),
        .RESULT_BYTE_O(byte_o), .RESULT_VALID_O(valid),
        .INTERRUPT_CODE_FIELD_O(code), .ERROR_O(err));
    drive_model drive_model_inst (.clk_i(clk), .spin_i(spin),
        .protect_i(prot), .index_o(index), .wp_o(wp));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // one whole command: start, execution, result read, release
    task run(input xfer_status_pkg::cmd_kind_t k, input logic t, s, p,
             input logic [7:0] x1, x2);
        @(posedge clk) kind <= k;
        start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        active <= 1'b1;
        tc <= t;
        @(posedge clk) tc <= 1'b0;
        evt <= e;
        @(posedge clk) evt <= '0;
        spin <= s;
        prot <= p;
        repeat (20) @(posedge clk);
        #1 chk("byte in execution", 8'h00, byte_o);
        @(posedge clk) active <= 1'b0;
        spin <= 1'b0;
        prot <= 1'b0;
        for (int i = 0; i < 10 && valid !== 1'b1; i++) @(posedge clk);
        @(posedge clk) sel <= 1'b0;
        #1 chk("status one", x1, byte_o);
        chk("valid", 8'h01, {7'h0, valid});
        // an event while the result is held must not reach the bytes
        @(posedge clk) sel <= 1'b1;
        evt.mark_timeout <= 1'b1;
        #1 chk("status two", x2, byte_o);
        chk("code", ((x1 | x2) != 0) ? 8'h01 : 8'h00, {6'h0, code});
        chk("error", {7'h0, (x1 | x2) != 0}, {7'h0, err});
        @(posedge clk) done <= 1'b1;
        evt <= '0;
        #1 chk("held two", x2, byte_o);
        @(posedge clk) done <= 1'b0;
        #1 chk("released", 8'h00, {7'h0, valid});
        e = '0;
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    task t_crc;
        e.data_crc_bad = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h20, 8'h20);
        e.id_crc_bad = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h20, 8'h00);
    endtask : t_crc
    task t_absent;
        e.sector_miss = 1'b1;
        run(xfer_status_pkg::CMD_READ_DELETED, 0, 0, 0, 8'h04, 8'h00);
        e.id_crc_bad = 1'b1;
        run(xfer_status_pkg::CMD_READ_ID, 0, 0, 0, 8'h24, 8'h00);
        e.sequence_bad = 1'b1;
        run(xfer_status_pkg::CMD_READ_TRACK, 0, 0, 0, 8'h04, 8'h00);
    endtask : t_absent
    task t_overflow;
        e.sector_step = 1'b1;
        e.sector_num = 8'hff;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h80, 8'h00);
        e.xfer_done = 1'b1;
        run(xfer_status_pkg::CMD_WRITE_DATA, 0, 0, 0, 8'h80, 8'h00);
        e.xfer_done = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 1, 0, 0, 8'h00, 8'h00);
    endtask : t_overflow
    task t_marks;
        e.mark_timeout = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h01, 8'h01);
        run(xfer_status_pkg::CMD_READ_DATA, 0, 1, 0, 8'h01, 8'h00);
    endtask : t_marks
    task t_clash;
        e.deleted_mark = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h00, 8'h40);
        e.data_mark = 1'b1;
        run(xfer_status_pkg::CMD_READ_DELETED, 0, 0, 0, 8'h00, 8'h40);
    endtask : t_clash
    task t_track;
        e.id_seen = 1'b1;
        e.id_cylinder = 8'h05;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h00, 8'h10);
        e.id_seen = 1'b1;
        e.id_cylinder = 8'hff;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h00, 8'h12);
    endtask : t_track
    task t_late_protect;
        e.late_service = 1'b1;
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 0, 8'h10, 8'h00);
        run(xfer_status_pkg::CMD_WRITE_DATA, 0, 0, 1, 8'h02, 8'h00);
        run(xfer_status_pkg::CMD_WRITE_DELETED, 0, 0, 1, 8'h02, 8'h00);
        run(xfer_status_pkg::CMD_FORMAT, 0, 0, 1, 8'h02, 8'h00);
        run(xfer_status_pkg::CMD_READ_DATA, 0, 0, 1, 8'h00, 8'h00);
    endtask : t_late_protect
    ////////////////////////////////////////////////////////////////////////
    initial begin
        e = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_crc();
        t_absent();
        t_overflow();
        t_marks();
        t_clash();
        t_track();
        t_late_protect();
        summarize();
    end
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
endmodule : test_disk_transfer_error_status
